// *** design/ledi2c_pkg.sv ***
// shared constants and types for the led driver two-wire command decoder
package ledi2c_pkg;

    localparam int          NUM_CH             = 8;
    localparam logic [6:0]  SLAVE_ADDR         = 7'h1b;

    // command codes carried in the top three bits of the command byte
    localparam logic [2:0]  CMD_APPLY          = 3'h0;
    localparam logic [2:0]  CMD_WRITE          = 3'h1;
    localparam logic [2:0]  CMD_WRITE_APPLY    = 3'h2;
    localparam logic [2:0]  CMD_ALL_LEVEL      = 3'h3;
    localparam logic [2:0]  CMD_ALL_PWM        = 3'h4;

    // register map, five-bit register addresses
    localparam logic [4:0]  REG_LEVEL_BASE     = 5'h00;
    localparam logic [4:0]  REG_PWM_BASE       = 5'h08;
    localparam logic [4:0]  REG_OUTPUT_ENABLE  = 5'h10;
    localparam logic [4:0]  REG_STATUS         = 5'h11;

    // status fields and reset values
    localparam int          OVERTEMP_FLAG_BIT  = 0;
    localparam int          LOW_POWER_FLAG_BIT = 2;
    localparam logic [7:0]  REG_RESET          = 8'h00;

    // pwm frame: code 3f gives full on, so the frame is 63 steps
    localparam logic [5:0]  PWM_LAST_STEP      = 6'h3e;

    // low-power entry delay
    localparam int          SYS_CLK_KHZ        = 20000;
    localparam int          LOWPWR_TIME_MS     = 5;
    localparam int          LOWPWR_CYCLES      = LOWPWR_TIME_MS * SYS_CLK_KHZ;
    localparam int          LOWPWR_CNT_W       = 17;

    typedef logic [7:0]            ledi2c_byte_t;
    typedef logic [7:0][7:0]       ledi2c_bank_t;
    typedef logic [7:0][4:0]       ledi2c_level_t;

    // command byte as it crosses from the link domain
    typedef struct packed {
        logic [2:0] cmd;
        logic [4:0] addr;
    } ledi2c_cmd_s;

    typedef enum {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_DATA,
        PH_READ
    } ledi2c_phase_e;

endpackage

// *** design/ledi2c_pwm.sv ***
// one channel pwm comparator with registered drive
`timescale 1ns/1ps
module ledi2c_pwm (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [5:0] step_in,
    input  wire logic [5:0] duty_in,
    input  wire logic       enable_in,
    output logic            drive_out
);
    import ledi2c_pkg::*;

    logic next_drive;

    // on while the frame step is below the six-bit code: 20 hex is half
    always_comb begin
        next_drive = enable_in && (step_in < duty_in);
    end

    // drive register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            drive_out <= 1'b0;
        end else begin
            drive_out <= next_drive;
        end
    end

    // a disabled channel never drives one cycle later
    a_pwm_disabled_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !enable_in |=> !drive_out) else $error("disabled channel drove");

endmodule

// *** design/ledi2c_top.sv ***
// led driver two-wire slave: command decoder, staged and active registers
`timescale 1ns/1ps
module ledi2c_top #(
    parameter int LOWPWR_CYCLES = ledi2c_pkg::LOWPWR_CYCLES
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe_out,
    input  wire logic                  overtemp_in,
    output logic [7:0]                 chan_drive_out,
    output ledi2c_pkg::ledi2c_level_t  chan_level_out,
    output logic                       low_power_out
);
    import ledi2c_pkg::*;

    // ---------------- link domain (scl clocked) ----------------
    logic           lrst_meta;
    logic           lrst_n;
    logic           start_tgl;
    logic           stop_tgl;
    logic           start_seen;
    ledi2c_phase_e  phase;
    logic [3:0]     bit_cnt;
    ledi2c_byte_t   shreg;
    logic           ack_due;
    logic           rw_bit;
    ledi2c_cmd_s    cmd_word;
    ledi2c_byte_t   data_word;
    logic           cmd_tgl;
    logic           wr_tgl;
    ledi2c_phase_e  next_phase;
    logic [3:0]     next_bit_cnt;
    ledi2c_byte_t   next_shreg;
    logic           next_ack_due;
    logic           next_rw_bit;
    ledi2c_cmd_s    next_cmd_word;
    ledi2c_byte_t   next_data_word;
    logic           next_cmd_tgl;
    logic           next_wr_tgl;
    logic           next_sda_oe;
    ledi2c_byte_t   byte_in;
    ledi2c_byte_t   rd_byte;

    // system reset carried into the link domain
    always_ff @(posedge scl_in) begin
        lrst_meta <= rst_n_in;
        lrst_n    <= lrst_meta;
    end

    // start and stop are sda edges while scl is high; toggles survive a stopped scl
    always_ff @(negedge sda_in) begin
        if (!rst_n_in) begin
            start_tgl <= 1'b0;
        end else if (scl_in) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge sda_in) begin
        if (!rst_n_in) begin
            stop_tgl <= 1'b0;
        end else if (scl_in) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    assign byte_in = {shreg[6:0], sda_in};

    // bit and byte sequencing, sampled on the rising scl edge
    always_comb begin
        next_phase     = phase;
        next_bit_cnt   = bit_cnt;
        next_shreg     = shreg;
        next_ack_due   = ack_due;
        next_rw_bit    = rw_bit;
        next_cmd_word  = cmd_word;
        next_data_word = data_word;
        next_cmd_tgl   = cmd_tgl;
        next_wr_tgl    = wr_tgl;
        if (start_tgl != start_seen) begin
            // start or repeated start: this edge carries the first address bit
            next_phase   = PH_ADDR;
            next_bit_cnt = 4'h1;
            next_shreg   = {7'h00, sda_in};
            next_ack_due = 1'b0;
        end else begin
            case (phase)
                PH_ADDR, PH_CMD, PH_DATA: begin
                    if (bit_cnt < 4'h8) begin
                        next_shreg   = byte_in;
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            next_ack_due = 1'b1;
                            if (phase == PH_ADDR) begin
                                next_ack_due = (byte_in[7:1] == SLAVE_ADDR);
                                next_rw_bit  = byte_in[0];
                            end else if (phase == PH_CMD) begin
                                next_cmd_word = byte_in;
                                next_cmd_tgl  = ~cmd_tgl;
                            end else begin
                                next_data_word = byte_in;
                                next_wr_tgl    = ~wr_tgl;
                            end
                        end
                    end else begin
                        // ack clock: choose what follows
                        next_bit_cnt = 4'h0;
                        next_ack_due = 1'b0;
                        if (phase == PH_ADDR) begin
                            if (!ack_due) begin
                                next_phase = PH_IDLE;
                            end else if (rw_bit) begin
                                next_phase = PH_READ;
                                next_shreg = rd_byte;
                            end else begin
                                next_phase = PH_CMD;
                            end
                        end else begin
                            next_phase = PH_DATA;
                        end
                    end
                end
                PH_READ: begin
                    if (bit_cnt < 4'h8) begin
                        next_shreg   = {shreg[6:0], 1'b0};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (sda_in) begin
                        next_phase = PH_IDLE;
                    end else begin
                        next_shreg   = rd_byte;
                        next_bit_cnt = 4'h0;
                    end
                end
                default: begin
                    next_phase = PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_in) begin
        if (!lrst_n) begin
            phase      <= PH_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= REG_RESET;
            ack_due    <= 1'b0;
            rw_bit     <= 1'b0;
            cmd_word   <= '0;
            data_word  <= REG_RESET;
            cmd_tgl    <= 1'b0;
            wr_tgl     <= 1'b0;
            start_seen <= start_tgl;
        end else begin
            phase      <= next_phase;
            bit_cnt    <= next_bit_cnt;
            shreg      <= next_shreg;
            ack_due    <= next_ack_due;
            rw_bit     <= next_rw_bit;
            cmd_word   <= next_cmd_word;
            data_word  <= next_data_word;
            cmd_tgl    <= next_cmd_tgl;
            wr_tgl     <= next_wr_tgl;
            start_seen <= start_tgl;
        end
    end

    // sda pull-down changes only while scl is low
    always_comb begin
        next_sda_oe = ((phase != PH_READ) && (phase != PH_IDLE) && (bit_cnt == 4'h8) && ack_due)
                   || ((phase == PH_READ) && (bit_cnt < 4'h8) && !shreg[7]);
    end

    always_ff @(negedge scl_in) begin
        if (!lrst_n) begin
            sda_oe_out <= 1'b0;
            sda_out    <= 1'b0;
        end else begin
            sda_oe_out <= next_sda_oe;
            sda_out    <= 1'b0; // open drain: only ever pulls low
        end
    end

    sequence s_our_addr;
        (phase == PH_ADDR) && (bit_cnt == 4'h7) && (shreg[6:0] == SLAVE_ADDR);
    endsequence

    a_addr_match_ack: assert property (@(posedge scl_in) disable iff (!lrst_n)
        (start_tgl == start_seen) and s_our_addr |=> ack_due) else $error("own address not acked");

    a_foreign_addr_idle: assert property (@(posedge scl_in) disable iff (!lrst_n)
        (start_tgl == start_seen) && (phase == PH_ADDR) && (bit_cnt == 4'h8) && !ack_due
        |=> (phase == PH_IDLE) && $stable(cmd_tgl) && $stable(wr_tgl)) else $error("foreign address acted on");

    // ---------------- system domain ----------------
    logic [4:0]          sync_meta;
    logic [4:0]          sync_q;
    logic [3:0]          sync_prev;
    logic                cmd_evt;
    logic                wr_evt;
    logic                start_evt;
    logic                stop_evt;
    logic                overtemp;
    ledi2c_cmd_s         cmd_q;
    logic                apply_pend;
    ledi2c_bank_t        level_stage;
    ledi2c_bank_t        pwm_stage;
    ledi2c_byte_t        oe_stage;
    ledi2c_bank_t        level_act;
    ledi2c_bank_t        pwm_act;
    ledi2c_byte_t        oe_act;
    logic [LOWPWR_CNT_W-1:0] lp_cnt;
    logic                low_power;
    logic [5:0]          pwm_step;
    ledi2c_byte_t        status;
    ledi2c_cmd_s         next_cmd_q;
    logic                next_apply_pend;
    ledi2c_bank_t        next_level_stage;
    ledi2c_bank_t        next_pwm_stage;
    ledi2c_byte_t        next_oe_stage;
    ledi2c_bank_t        next_level_act;
    ledi2c_bank_t        next_pwm_act;
    ledi2c_byte_t        next_oe_act;
    logic [LOWPWR_CNT_W-1:0] next_lp_cnt;
    logic                next_low_power;
    logic [5:0]          next_pwm_step;
    ledi2c_byte_t        next_rd_byte;
    ledi2c_level_t       next_level_out;

    // bank decode shared by write and read paths
    function automatic logic in_bank(input logic [4:0] a, input logic [4:0] base);
        return a[4:3] == base[4:3];
    endfunction

    function automatic ledi2c_byte_t reg_pick(input logic [4:0] a, input ledi2c_bank_t lv,
                                              input ledi2c_bank_t pw, input ledi2c_byte_t oe,
                                              input ledi2c_byte_t st);
        if (in_bank(a, REG_LEVEL_BASE)) begin
            return lv[a[2:0]];
        end else if (in_bank(a, REG_PWM_BASE)) begin
            return pw[a[2:0]];
        end else if (a == REG_OUTPUT_ENABLE) begin
            return oe;
        end else if (a == REG_STATUS) begin
            return st;
        end
        return REG_RESET;
    endfunction

    // toggles and the over-temperature pin pass two flops before use
    always_ff @(posedge sys_clk_in) begin
        sync_meta <= {overtemp_in, stop_tgl, start_tgl, wr_tgl, cmd_tgl};
        sync_q    <= sync_meta;
        if (!rst_n_in) begin
            sync_prev <= 4'h0;
        end else begin
            sync_prev <= sync_q[3:0];
        end
    end

    assign cmd_evt   = sync_q[0] ^ sync_prev[0];
    assign wr_evt    = sync_q[1] ^ sync_prev[1];
    assign start_evt = sync_q[2] ^ sync_prev[2];
    assign stop_evt  = sync_q[3] ^ sync_prev[3];
    assign overtemp  = sync_q[4];
    assign status    = {5'h00, low_power, 1'b0, overtemp};

    // command decode, staging, apply and low-power timer
    always_comb begin
        next_cmd_q       = cmd_q;
        next_apply_pend  = apply_pend;
        next_level_stage = level_stage;
        next_pwm_stage   = pwm_stage;
        next_oe_stage    = oe_stage;
        next_level_act   = level_act;
        next_pwm_act     = pwm_act;
        next_oe_act      = oe_act;
        next_lp_cnt      = lp_cnt;
        next_low_power   = low_power;
        next_pwm_step    = (pwm_step == PWM_LAST_STEP) ? 6'h00 : pwm_step + 6'h01;
        // the link words are stable for several scl bits after their toggle lands
        if (cmd_evt) begin
            next_cmd_q      = cmd_word;
            next_apply_pend = (cmd_word.cmd == CMD_APPLY);
        end
        if (wr_evt) begin
            case (cmd_q.cmd)
                CMD_ALL_LEVEL: begin
                    next_level_stage = {NUM_CH{data_word}};
                end
                CMD_ALL_PWM: begin
                    next_pwm_stage = {NUM_CH{data_word}};
                end
                CMD_WRITE, CMD_WRITE_APPLY: begin
                    if (in_bank(cmd_q.addr, REG_LEVEL_BASE)) begin
                        next_level_stage[cmd_q.addr[2:0]] = data_word;
                    end else if (in_bank(cmd_q.addr, REG_PWM_BASE)) begin
                        next_pwm_stage[cmd_q.addr[2:0]] = data_word;
                    end else if (cmd_q.addr == REG_OUTPUT_ENABLE) begin
                        next_oe_stage = data_word;
                    end
                end
                default: begin
                end
            endcase
        end
        // staged values reach the outputs only on 010 or a finished 000
        if ((wr_evt && (cmd_q.cmd == CMD_WRITE_APPLY)) || (stop_evt && apply_pend)) begin
            next_level_act = next_level_stage;
            next_pwm_act   = next_pwm_stage;
            next_oe_act    = next_oe_stage;
        end
        // a command landing with a stop keeps its pending apply: set wins
        if (stop_evt && !cmd_evt) begin
            next_apply_pend = 1'b0;
        end
        // any bus traffic restarts the idle timer and wakes the part
        if (start_evt || cmd_evt || wr_evt || stop_evt) begin
            next_lp_cnt    = '0;
            next_low_power = 1'b0;
        end else if (oe_act != REG_RESET) begin
            next_lp_cnt = '0;
        end else if (!low_power) begin
            if (lp_cnt == LOWPWR_CNT_W'(LOWPWR_CYCLES - 1)) begin
                next_low_power = 1'b1;
            end else begin
                next_lp_cnt = lp_cnt + 1'b1;
            end
        end
        next_rd_byte = reg_pick(cmd_q.addr, level_stage, pwm_stage, oe_stage, status);
        for (int i = 0; i < NUM_CH; i++) begin
            next_level_out[i] = level_act[i][4:0];
        end
    end

    // reset clears every register, staged and active
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cmd_q          <= '0;
            apply_pend     <= 1'b0;
            level_stage    <= '0;
            pwm_stage      <= '0;
            oe_stage       <= REG_RESET;
            level_act      <= '0;
            pwm_act        <= '0;
            oe_act         <= REG_RESET;
            lp_cnt         <= '0;
            low_power      <= 1'b0;
            pwm_step       <= 6'h00;
            rd_byte        <= REG_RESET;
            chan_level_out <= '0;
            low_power_out  <= 1'b0;
        end else begin
            cmd_q          <= next_cmd_q;
            apply_pend     <= next_apply_pend;
            level_stage    <= next_level_stage;
            pwm_stage      <= next_pwm_stage;
            oe_stage       <= next_oe_stage;
            level_act      <= next_level_act;
            pwm_act        <= next_pwm_act;
            oe_act         <= next_oe_act;
            lp_cnt         <= next_lp_cnt;
            low_power      <= next_low_power;
            pwm_step       <= next_pwm_step;
            rd_byte        <= next_rd_byte;
            chan_level_out <= next_level_out;
            low_power_out  <= next_low_power;
        end
    end

    // one pwm per channel; enable bit i drives channel i, over-temperature forces all off
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        ledi2c_pwm u_pwm (
            .sys_clk_in (sys_clk_in),
            .rst_n_in   (rst_n_in),
            .step_in    (pwm_step),
            .duty_in    (pwm_act[g][5:0]),
            .enable_in  (oe_act[g] && !overtemp && !low_power),
            .drive_out  (chan_drive_out[g])
        );
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_bcast_level: assert property (wr_evt && (cmd_q.cmd == CMD_ALL_LEVEL)
        |=> level_stage == {NUM_CH{$past(data_word)}}) else $error("level broadcast missed");
    a_bcast_pwm: assert property (wr_evt && (cmd_q.cmd == CMD_ALL_PWM)
        |=> pwm_stage == {NUM_CH{$past(data_word)}}) else $error("pwm broadcast missed");
    a_staged_hold: assert property (wr_evt && (cmd_q.cmd == CMD_WRITE) && !stop_evt
        |=> $stable(oe_act) && $stable(level_act) && $stable(pwm_act)) else $error("staged write leaked");
    a_single_oe: assert property (wr_evt && (cmd_q.cmd == CMD_WRITE) && (cmd_q.addr == REG_OUTPUT_ENABLE)
        |=> oe_stage == $past(data_word)) else $error("enable write lost");

    sequence s_write_apply;
        wr_evt && (cmd_q.cmd == CMD_WRITE_APPLY);
    endsequence
    a_apply_now: assert property (s_write_apply
        |=> (oe_act == oe_stage) && (pwm_act == pwm_stage) && (level_act == level_stage)) else $error("010 no apply");

    sequence s_apply_stop;
        stop_evt && apply_pend && !wr_evt;
    endsequence
    a_apply_stop: assert property (s_apply_stop
        |=> (level_act == level_stage) && (oe_act == oe_stage) && !apply_pend) else $error("000 no apply");

    a_read_pwm1: assert property ((cmd_q.addr == REG_PWM_BASE)
        |=> rd_byte == $past(pwm_stage[0])) else $error("pwm one readback wrong");
    a_status_temp: assert property ((cmd_q.addr == REG_STATUS)
        |=> rd_byte[OVERTEMP_FLAG_BIT] == $past(overtemp)) else $error("status temp bit wrong");
    a_wake_traffic: assert property (start_evt |=> !low_power ##1 !low_power_out) else $error("no wake");
    a_reset_clear: assert property (@(posedge sys_clk_in) disable iff (1'b0) !rst_n_in
        |=> (oe_act == REG_RESET) && (level_stage == '0)) else $error("reset left state");

endmodule

// *** tb/ledi2c_mst.sv ***
// two-wire master model: clock, open-drain pull on data, bit and byte transfers
`timescale 1ns/1ps
module ledi2c_mst (
    output logic      scl_out,
    output logic      low_out,
    input  wire logic sda_in
);
    // released bus idles high through the pull-up
    initial begin
        scl_out = 1'b1;
        low_out = 1'b0;
    end
    // data changes in the low phase only, sampled mid high phase
    task automatic bit_x(input logic b, output logic s);
        low_out = !b;
        #20 scl_out = 1'b1;
        #20 s = sda_in;
        #20 scl_out = 1'b0;
        #20;
    endtask
    // start or repeated start, leaves clock low
    task automatic start();
        low_out = 1'b0;
        #20 scl_out = 1'b1;
        #40 low_out = 1'b1;
        #40 scl_out = 1'b0;
    endtask
    // stop, then bus free time before the next start
    task automatic stop();
        low_out = 1'b1;
        #20 scl_out = 1'b1;
        #40 low_out = 1'b0;
        #320;
    endtask
    // eight bits msb first, then the ninth bit m
    task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(m, a);
    endtask
endmodule

// *** tb/led_driver_i2c_command_decoder_test.sv ***
// self-checking bench for the led driver command decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module led_driver_i2c_command_decoder_test;
    import ledi2c_pkg::*;
    logic          sys_clk_in = 1'b0;
    logic          rst_n_in = 1'b0;
    logic          overtemp_in = 1'b0;
    logic          scl;
    logic          low;
    logic          sda_oe_out;
    logic          sda_out;
    logic [7:0]    chan_drive_out;
    ledi2c_level_t chan_level_out;
    logic          low_power_out;
    logic [7:0]    rd;
    logic          ak;
    int            err_total = 0;
    int            comparisons = 0;
    int            cyc = 0;
    // open-drain wire: any party pulling wins over the pull-up
    // while enabled the slave's data value goes on the wire, so a stuck-high value loses every ack
    wire           sda = sda_oe_out ? (sda_out && !low) : !low;
    ledi2c_top #(.LOWPWR_CYCLES(50)) i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .overtemp_in(overtemp_in),
        .chan_drive_out(chan_drive_out), .chan_level_out(chan_level_out), .low_power_out(low_power_out));
    ledi2c_mst i_mst (.scl_out(scl), .low_out(low), .sda_in(sda));
    always #25 sys_clk_in = !sys_clk_in;
    // hang guard, far above the expected run length
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        i_mst.byte_x(b, 1'b1, rd, ak);
        `CHK("ack", 1'b0, ak)
    endtask
    task automatic wr(input logic [2:0] c, input logic [4:0] a, input logic [7:0] d, input bit nd);
        i_mst.start();
        send({SLAVE_ADDR, 1'b0});
        send({c, a});
        if (nd) begin
            send(d);
        end
        i_mst.stop();
    endtask
    // read waits 1 us before the repeated start so the address settles
    task automatic rdr(input logic [4:0] a, input logic [7:0] e);
        i_mst.start();
        send({SLAVE_ADDR, 1'b0});
        send({CMD_WRITE, a});
        #1000;
        i_mst.start();
        send({SLAVE_ADDR, 1'b1});
        i_mst.byte_x(8'hff, 1'b1, rd, ak);
        i_mst.stop();
        `CHK("rdata", e, rd)
    endtask
    task automatic duty(input int ch, input logic [6:0] e);
        logic [6:0] n;
        n = 7'h00;
        repeat (63) begin
            @(negedge sys_clk_in);
            n += 7'(chan_drive_out[ch]);
        end
        `CHK("duty", e, n)
    endtask
    // foreign address is refused and reset values stand
    task automatic t_reset();
        i_mst.start();
        i_mst.byte_x({7'h1c, 1'b0}, 1'b1, rd, ak);
        `CHK("nack", 1'b1, ak)
        i_mst.stop();
        rdr(REG_OUTPUT_ENABLE, 8'h00);
        `CHK("lvl", 40'h0, chan_level_out)
    endtask
    // broadcasts and single writes stay staged
    task automatic t_stage();
        wr(CMD_ALL_LEVEL, 5'h1f, 8'h05, 1);
        wr(CMD_WRITE, 5'h07, 8'h0b, 1);
        wr(CMD_ALL_PWM, 5'h02, 8'h20, 1);
        wr(CMD_WRITE, REG_OUTPUT_ENABLE, 8'h8f, 1);
        `CHK("lvl", 40'h0, chan_level_out)
        `CHK("drv", 8'h00, chan_drive_out)
        rdr(5'h07, 8'h0b);
        rdr(5'h06, 8'h05);
        rdr(REG_PWM_BASE, 8'h20);
        rdr(5'h0f, 8'h20);
    endtask
    // bare apply, then write-and-apply carrying a staged level along
    task automatic t_apply();
        wr(CMD_APPLY, 5'h00, 8'h00, 0);
        `CHK("lvl", {5'h0b, {7{5'h05}}}, chan_level_out)
        duty(0, 7'h20);
        duty(4, 7'h00);
        wr(CMD_WRITE, REG_LEVEL_BASE, 8'h11, 1);
        wr(CMD_WRITE_APPLY, REG_OUTPUT_ENABLE, 8'h0f, 1);
        `CHK("lvl0", 5'h11, chan_level_out[0])
        duty(7, 7'h00);
        duty(3, 7'h20);
    endtask
    // over-temperature shows in status and forces drives off
    task automatic t_status();
        @(posedge sys_clk_in);
        overtemp_in <= 1'b1;
        // two sync flops plus the drive flop before the channel goes dark
        repeat (4) @(posedge sys_clk_in);
        duty(0, 7'h00);
        rdr(REG_STATUS, 8'h01);
        @(posedge sys_clk_in);
        overtemp_in <= 1'b0;
        rdr(REG_STATUS, 8'h00);
    endtask
    // idle with all outputs off sleeps, traffic wakes, contents kept
    task automatic t_lowpwr();
        wr(CMD_WRITE_APPLY, REG_OUTPUT_ENABLE, 8'h00, 1);
        repeat (70) @(posedge sys_clk_in);
        `CHK("lp", 1'b1, low_power_out)
        rdr(5'h07, 8'h0b);
        `CHK("lp", 1'b0, low_power_out)
    endtask
    // link flops need clock and data edges while reset is held
    initial begin
        repeat (3) begin
            i_mst.stop();
        end
        // link reset is only taken on scl edges, so clock it while reset is low
        repeat (5) begin
            i_mst.bit_x(1'b1, ak);
        end
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) begin
            i_mst.bit_x(1'b1, ak);
        end
        t_reset();
        t_stage();
        t_apply();
        t_status();
        t_lowpwr();
        give_verdict();
    end
endmodule
